/* File: design/rtp_pkg.sv */
package rtp_pkg;
   // fixed target address, upper seven bits of the address byte
   localparam logic [6:0] TARGET_ADDR = 7'h68;
   localparam int BYTE_BITS = 8;
   localparam int CLK_PERIOD_NS = 10;
   // link clock half period made by the controller end: 80 ns at 100 MHz
   localparam int SCL_HALF_NS = 80;
   localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_PERIOD_NS;
   // timeout window, in oscillator ticks
   localparam int SCL_LOW_SAFE_TICKS = 8;
   localparam int SCL_LOW_RESET_TICKS = 12;
   localparam int TICK_W = 8;
endpackage

/* File: design/rtp_bus_if.sv */
`timescale 1ns/10ps
interface rtp_bus_if;
   logic scl_o;
   logic scl_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic scl;
   logic sda;
   // sda wired-and with pull-up; scl follows scl_o when scl_oe is set, else pulled up
   assign scl = scl_oe ? scl_o : 1'b1;
   assign sda = (sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o)
      ? 1'b0 : 1'b1;
   modport target (input scl, input sda, output sda_dev_o,
      output sda_dev_oe);
   modport ctrl (input scl, input sda, output scl_o, output scl_oe,
      output sda_host_o, output sda_host_oe);
endinterface

/* File: design/rtp_target.sv */
`timescale 1ns/10ps
// ****************************************
// target end
// ****************************************
// How it works
// - read bytes go out msb first, ack sampled
// - controller nacks last read byte
// - first byte: address upper, direction bit0
// - respond only to fixed address, write or read
// - direction one means read, drive data
// - mismatch ignored until next start
// - byte after write address is pointer
// - controller single write sequence
// - many data bytes accepted until stop
// - read uses internal address counter
// - controller single read sequence
// - dummy write loads counter, repeated start
// - keep sending while controller acks
// - controller keeps scl low short
// - long scl low resets interface
// - timeout only while oscillator runs
// - never stretch scl
// - sda only pulled low or released
// - ninth bit is acknowledge
// - sample on rise, change after fall
// - start and stop while scl high
module rtp_target (
   input wire logic mclk,
   input wire logic sys_rst,
   rtp_bus_if.target bus,
   input wire logic osc_run,
   input wire logic osc_tick,
   input wire logic [7:0] rd_data,
   output logic [7:0] mem_addr,
   output logic [7:0] wr_data,
   output logic wr_stb,
   output logic timeout_evt
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RX = 5'b00010,
      ST_ACK = 5'b00100,
      ST_TX = 5'b01000,
      ST_MACK = 5'b10000
   } rtp_state_t;

   // ****************************************
   // pin synchronisers and edge detect
   // ****************************************
   logic [1:0] scl_s_r, scl_s_nxt, sda_s_r, sda_s_nxt;
   logic scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;
   logic scl_rise, scl_fall, start_c, stop_c;

   always_comb begin
      scl_s_nxt = {scl_s_r[0], bus.scl};
      sda_s_nxt = {sda_s_r[0], bus.sda};
      scl_d_nxt = scl_s_r[1];
      sda_d_nxt = sda_s_r[1];
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_s_r <= 2'h3;
         sda_s_r <= 2'h3;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_s_r <= scl_s_nxt;
         sda_s_r <= sda_s_nxt;
         scl_d_r <= scl_d_nxt;
         sda_d_r <= sda_d_nxt;
      end
   end

   assign scl_rise = scl_s_r[1] & ~scl_d_r;
   assign scl_fall = ~scl_s_r[1] & scl_d_r;
   assign start_c = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
   assign stop_c = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

   // ****************************************
   // protocol engine
   // ****************************************
   rtp_state_t st_r, st_nxt;
   logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, wd_r, wd_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [1:0] byte_r, byte_nxt; // 0 address, 1 pointer, 2 data
   logic rd_r, rd_nxt, ack_r, ack_nxt, drv_r, drv_nxt, wstb_r, wstb_nxt;
   logic [rtp_pkg::TICK_W-1:0] to_r, to_nxt;
   logic to_hit, evt_r, evt_nxt;

   // oscillator ticks count while scl low; stopped oscillator never fires
   assign to_hit = osc_run & ~scl_s_r[1] & osc_tick & st_r != ST_IDLE
      & to_r == rtp_pkg::TICK_W'(rtp_pkg::SCL_LOW_RESET_TICKS - 1);

   always_comb begin
      st_nxt = st_r;
      sh_nxt = sh_r;
      ptr_nxt = ptr_r;
      wd_nxt = wd_r;
      bit_nxt = bit_r;
      byte_nxt = byte_r;
      rd_nxt = rd_r;
      ack_nxt = ack_r;
      drv_nxt = drv_r;
      wstb_nxt = 1'b0;
      evt_nxt = to_hit;
      to_nxt = to_r;
      if (scl_rise || !osc_run) begin
         to_nxt = '0;
      end else if (osc_tick && !scl_s_r[1] && !to_hit) begin
         to_nxt = to_r + 1'b1;
      end
      if (to_hit) begin
         st_nxt = ST_IDLE;
         drv_nxt = 1'b0;
         to_nxt = '0;
      end else if (start_c) begin
         st_nxt = ST_RX;
         bit_nxt = '0;
         byte_nxt = 2'h0;
         drv_nxt = 1'b0;
      end else if (stop_c) begin
         st_nxt = ST_IDLE;
         drv_nxt = 1'b0;
      end else begin
         case (st_r)
            ST_RX: begin
               if (scl_rise) begin
                  sh_nxt = {sh_r[6:0], sda_s_r[1]};
                  bit_nxt = bit_r + 1'b1;
               end else if (scl_fall && bit_r == 4'(rtp_pkg::BYTE_BITS))
               begin
                  bit_nxt = '0;
                  if (byte_r == 2'h0) begin
                     if (sh_r[7:1] == rtp_pkg::TARGET_ADDR) begin
                        rd_nxt = sh_r[0];
                        drv_nxt = 1'b1;
                        st_nxt = ST_ACK;
                     end else begin
                        st_nxt = ST_IDLE;
                     end
                  end else begin
                     if (byte_r == 2'h1) begin
                        ptr_nxt = sh_r;
                     end else begin
                        wd_nxt = sh_r;
                        wstb_nxt = 1'b1;
                     end
                     drv_nxt = 1'b1;
                     st_nxt = ST_ACK;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  drv_nxt = 1'b0;
                  bit_nxt = '0;
                  if (byte_r == 2'h0 && rd_r) begin
                     sh_nxt = rd_data;
                     drv_nxt = ~rd_data[7];
                     st_nxt = ST_TX;
                  end else begin
                     if (byte_r == 2'h2) begin
                        ptr_nxt = ptr_r + 1'b1;
                     end
                     byte_nxt = (byte_r == 2'h0) ? 2'h1 : 2'h2;
                     st_nxt = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  bit_nxt = bit_r + 1'b1;
                  if (bit_r == 4'(rtp_pkg::BYTE_BITS - 1)) begin
                     drv_nxt = 1'b0;
                     ptr_nxt = ptr_r + 1'b1;
                     st_nxt = ST_MACK;
                  end else begin
                     sh_nxt = {sh_r[6:0], 1'b0};
                     drv_nxt = ~sh_r[6];
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  ack_nxt = ~sda_s_r[1];
               end else if (scl_fall) begin
                  if (ack_r) begin
                     sh_nxt = rd_data;
                     bit_nxt = '0;
                     drv_nxt = ~rd_data[7];
                     st_nxt = ST_TX;
                  end else begin
                     st_nxt = ST_IDLE;
                  end
               end
            end
            ST_IDLE: begin
               drv_nxt = 1'b0;
            end
            default: begin
               st_nxt = ST_IDLE;
               drv_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= ST_IDLE;
         sh_r <= 8'h00;
         ptr_r <= 8'h00;
         wd_r <= 8'h00;
         bit_r <= 4'h0;
         byte_r <= 2'h0;
         rd_r <= 1'b0;
         ack_r <= 1'b0;
         drv_r <= 1'b0;
         wstb_r <= 1'b0;
         evt_r <= 1'b0;
         to_r <= '0;
      end else begin
         st_r <= st_nxt;
         sh_r <= sh_nxt;
         ptr_r <= ptr_nxt;
         wd_r <= wd_nxt;
         bit_r <= bit_nxt;
         byte_r <= byte_nxt;
         rd_r <= rd_nxt;
         ack_r <= ack_nxt;
         drv_r <= drv_nxt;
         wstb_r <= wstb_nxt;
         evt_r <= evt_nxt;
         to_r <= to_nxt;
      end
   end

   // open drain: output level is always low, only the enable moves;
   // scl has no driver here at all, so no stretching is possible
   assign bus.sda_dev_o = 1'b0;
   assign bus.sda_dev_oe = drv_r;
   assign mem_addr = ptr_r;
   assign wr_data = wd_r;
   assign wr_stb = wstb_r;
   // registered: the tick that fires it may be only half a clock wide
   assign timeout_evt = evt_r;
endmodule

/* File: design/rtp_ctrl.sv */
`timescale 1ns/10ps
// ****************************************
// controller end
// ****************************************
// one request per transfer: address cycle then len data bytes;
// use_ptr sends a pointer first (write) or dummy write plus
// repeated start (read)
module rtp_ctrl (
   input wire logic mclk,
   input wire logic sys_rst,
   rtp_bus_if.ctrl bus,
   input wire logic req,
   input wire logic req_rd,
   input wire logic req_use_ptr,
   input wire logic [7:0] req_ptr,
   input wire logic [7:0] req_len,
   input wire logic [7:0] wr_byte,
   output logic busy,
   output logic wr_take,
   output logic [7:0] rd_byte,
   output logic rd_valid,
   output logic nack_err
);
   typedef enum logic [5:0] {
      CS_IDLE = 6'b000001,
      CS_START = 6'b000010,
      CS_BIT = 6'b000100,
      CS_ACK = 6'b001000,
      CS_STOP = 6'b010000,
      CS_DONE = 6'b100000
   } rtp_cstate_t;

   rtp_cstate_t st_r, st_nxt;
   logic [7:0] div_r, div_nxt, sh_r, sh_nxt, len_r, len_nxt, rx_r, rx_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [1:0] stage_r, stage_nxt; // 0 addr,1 ptr,2 data,3 raddr
   logic rd_r, rd_nxt, scl_r, scl_nxt, sda_r, sda_nxt, err_r, err_nxt;
   logic rv_r, rv_nxt, take_r, take_nxt, up_r, up_nxt, tx_r, tx_nxt;
   logic [7:0] ptr_r, ptr_nxt;
   logic [1:0] sda_s_r;
   logic tick;

   assign tick = div_r == 8'(rtp_pkg::SCL_HALF_CYC - 1);

   always_comb begin
      st_nxt = st_r;
      div_nxt = tick ? 8'h00 : div_r + 1'b1;
      sh_nxt = sh_r;
      len_nxt = len_r;
      rx_nxt = rx_r;
      bit_nxt = bit_r;
      stage_nxt = stage_r;
      rd_nxt = rd_r;
      scl_nxt = scl_r;
      sda_nxt = sda_r;
      err_nxt = err_r;
      rv_nxt = 1'b0;
      take_nxt = 1'b0;
      up_nxt = up_r;
      tx_nxt = tx_r;
      ptr_nxt = ptr_r;
      case (st_r)
         CS_IDLE: begin
            if (req) begin
               rd_nxt = req_rd;
               up_nxt = req_use_ptr;
               ptr_nxt = req_ptr;
               len_nxt = req_len;
               err_nxt = 1'b0;
               stage_nxt = 2'h0;
               div_nxt = 8'h00;
               st_nxt = CS_START;
            end
         end
         CS_START: if (tick) begin
            if (scl_r && sda_r) begin
               sda_nxt = 1'b0;
            end else if (scl_r) begin
               scl_nxt = 1'b0;
               sh_nxt = {rtp_pkg::TARGET_ADDR,
                  (stage_r == 2'h3) ? 1'b1 : (rd_r & ~up_r)};
               bit_nxt = '0;
               tx_nxt = 1'b1;
               st_nxt = CS_BIT;
            end else begin
               scl_nxt = 1'b1;
            end
         end
         CS_BIT: if (tick) begin
            if (!scl_r && bit_r == 4'h0 && sda_r != (sh_r[7] | ~tx_r)) begin
               sda_nxt = sh_r[7] | ~tx_r;
            end else if (!scl_r) begin
               scl_nxt = 1'b1;
            end else begin
               scl_nxt = 1'b0;
               // synchronised copy: sda has stood a whole high phase
               rx_nxt = {rx_r[6:0], sda_s_r[1]};
               sh_nxt = {sh_r[6:0], 1'b1};
               bit_nxt = bit_r + 1'b1;
               if (bit_r == 4'h7) begin
                  // release for target ack, or drive our ack/nack
                  sda_nxt = tx_r ? 1'b1 : (len_r == 8'h01);
                  st_nxt = CS_ACK;
               end else begin
                  sda_nxt = sh_r[6] | ~tx_r;
               end
            end
         end
         CS_ACK: if (tick) begin
            if (!scl_r) begin
               scl_nxt = 1'b1;
            end else begin
               scl_nxt = 1'b0;
               bit_nxt = '0;
               if (!tx_r) begin
                  rv_nxt = 1'b1;
               end
               if (tx_r && sda_s_r[1]) begin
                  err_nxt = 1'b1;
                  sda_nxt = 1'b0;
                  st_nxt = CS_STOP;
               end else if (stage_r == 2'h0 && up_r) begin
                  stage_nxt = 2'h1;
                  sh_nxt = ptr_r;
                  sda_nxt = ptr_r[7];
                  st_nxt = CS_BIT;
               end else if (stage_r == 2'h1 && rd_r) begin
                  stage_nxt = 2'h3;
                  sda_nxt = 1'b1;
                  st_nxt = CS_START;
               end else if (len_r == 8'h00 || (stage_r == 2'h2
                  && len_r == 8'h01)) begin
                  sda_nxt = 1'b0;
                  st_nxt = CS_STOP;
               end else begin
                  if (stage_r == 2'h2) begin
                     len_nxt = len_r - 1'b1;
                  end
                  stage_nxt = 2'h2;
                  tx_nxt = ~rd_r;
                  take_nxt = ~rd_r;
                  sh_nxt = wr_byte;
                  sda_nxt = rd_r ? 1'b1 : wr_byte[7];
                  st_nxt = CS_BIT;
               end
            end
         end
         CS_STOP: if (tick) begin
            if (!scl_r) begin
               scl_nxt = 1'b1;
            end else begin
               sda_nxt = 1'b1;
               st_nxt = CS_DONE;
            end
         end
         CS_DONE: if (tick) begin
            st_nxt = CS_IDLE;
         end
         default: st_nxt = CS_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= CS_IDLE;
         div_r <= 8'h00;
         sh_r <= 8'h00;
         len_r <= 8'h00;
         rx_r <= 8'h00;
         bit_r <= 4'h0;
         stage_r <= 2'h0;
         rd_r <= 1'b0;
         scl_r <= 1'b1;
         sda_r <= 1'b1;
         err_r <= 1'b0;
         rv_r <= 1'b0;
         take_r <= 1'b0;
         up_r <= 1'b0;
         tx_r <= 1'b0;
         ptr_r <= 8'h00;
         sda_s_r <= 2'h3;
      end else begin
         st_r <= st_nxt;
         div_r <= div_nxt;
         sh_r <= sh_nxt;
         len_r <= len_nxt;
         rx_r <= rx_nxt;
         bit_r <= bit_nxt;
         stage_r <= stage_nxt;
         rd_r <= rd_nxt;
         scl_r <= scl_nxt;
         sda_r <= sda_nxt;
         err_r <= err_nxt;
         rv_r <= rv_nxt;
         take_r <= take_nxt;
         up_r <= up_nxt;
         tx_r <= tx_nxt;
         ptr_r <= ptr_nxt;
         sda_s_r <= {sda_s_r[0], bus.sda};
      end
   end

   // push-pull scl is allowed because the target never stretches
   assign bus.scl_o = scl_r;
   assign bus.scl_oe = 1'b1;
   assign bus.sda_host_o = 1'b0;
   assign bus.sda_host_oe = ~sda_r;
   assign busy = st_r != CS_IDLE;
   assign wr_take = take_r;
   assign rd_byte = rx_r;
   assign rd_valid = rv_r;
   assign nack_err = err_r;
endmodule

/* File: tb/rtp_chk.sv */
`timescale 1ns/10ps
// ****************************************
// wire checker on the ctrl/target pair
// ****************************************
module rtp_chk (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_host_o,
   input wire logic sda_host_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   chk_sda_low_only: assert property (sda_dev_oe |-> !sda_dev_o)
      else $error("target drove sda high");
   chk_scl_no_stretch: assert property (scl_oe && scl == scl_o)
      else $error("scl not owned by the controller");
   chk_dev_moves_low: assert property ($changed(sda_dev_oe) |-> !scl)
      else $error("target moved sda while scl high");
   // five samples lets the target's synchroniser settle first
   chk_bit_held: assert property (scl [*5] |-> $stable(sda_dev_oe))
      else $error("target bit changed in high phase");
   chk_high_phase: assert property ($rose(scl) |-> scl [*8])
      else $error("scl high phase too short");
   chk_low_short: assert property ($fell(scl) |-> ##[1:40] scl)
      else $error("scl held low too long");
   chk_start_clocks: assert property (
      $fell(sda) && scl && $past(scl) |-> ##[1:20] !scl)
      else $error("start not followed by clocking");
   chk_one_driver: assert property (
      !(scl && sda_dev_oe && sda_host_oe && !sda_host_o))
      else $error("both ends pull sda in one bit");
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
// ****************************************
// ctrl/target pair plus a bench-driven bus
// ****************************************
module testbench;
   logic mclk, sys_rst, osc_run, osc_tick, req, req_rd, req_use_ptr;
   logic busy, wr_take, rd_valid, nack_err, ws, ws2, tevt, tevt2, tseen;
   logic [7:0] req_ptr, req_len, wr_byte, rd_byte, ma, wd, ma2, wd2;
   logic [7:0] wbuf [4];
   logic [15:0] wq [$];
   logic [15:0] wq2 [$];
   logic [7:0] rq [$];
   int bad_count, checked, widx, tcnt;
   rtp_bus_if b1 ();
   // second bus: the bench plays a controller that breaks the rules
   rtp_bus_if b2 ();
   rtp_target rtp_target_inst (.mclk(mclk), .sys_rst(sys_rst), .bus(b1),
      .osc_run(osc_run), .osc_tick(osc_tick), .rd_data(ma ^ 8'h5A),
      .mem_addr(ma), .wr_data(wd), .wr_stb(ws), .timeout_evt(tevt));
   rtp_target rtp_target_inst2 (.mclk(mclk), .sys_rst(sys_rst), .bus(b2),
      .osc_run(osc_run), .osc_tick(osc_tick), .rd_data(ma2 ^ 8'h5A),
      .mem_addr(ma2), .wr_data(wd2), .wr_stb(ws2), .timeout_evt(tevt2));
   rtp_ctrl rtp_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst), .bus(b1),
      .req(req), .req_rd(req_rd), .req_use_ptr(req_use_ptr),
      .req_ptr(req_ptr), .req_len(req_len), .wr_byte(wr_byte), .busy(busy),
      .wr_take(wr_take), .rd_byte(rd_byte), .rd_valid(rd_valid),
      .nack_err(nack_err));
   rtp_chk rtp_chk_inst (.mclk(mclk), .sys_rst(sys_rst), .scl_o(b1.scl_o),
      .scl_oe(b1.scl_oe), .sda_host_o(b1.sda_host_o),
      .sda_host_oe(b1.sda_host_oe), .sda_dev_o(b1.sda_dev_o),
      .sda_dev_oe(b1.sda_dev_oe), .scl(b1.scl), .sda(b1.sda));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // oscillator ticks every 4 clocks, none while it is stopped
   always @(negedge mclk) begin
      tcnt = tcnt + 1;
      osc_tick = osc_run & (tcnt % 4 == 0);
      if (ws === 1'b1) wq.push_back({ma, wd});
      if (ws2 === 1'b1) wq2.push_back({ma2, wd2});
      if (rd_valid === 1'b1) rq.push_back(rd_byte);
      if (tevt2 === 1'b1) tseen = 1'b1;
      if (tevt !== 1'b0) begin
         bad_count++;
         $display("CHECK FAILED timeout_evt expected 0 seen %b", tevt);
      end
      if (wr_take === 1'b1) begin
         widx = widx + 1;
         wr_byte = wbuf[widx % 4];
      end
   end

   task automatic chk8(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_of_test;
      $display("checked %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic xfer(input logic rd, input logic up,
      input logic [7:0] ptr, input logic [7:0] len);
      wq.delete();
      rq.delete();
      req_rd = rd;
      req_use_ptr = up;
      req_ptr = ptr;
      req_len = len;
      req = 1'b1;
      repeat (10) if (busy !== 1'b1) @(negedge mclk);
      req = 1'b0;
      repeat (20000) if (busy !== 1'b0) @(negedge mclk);
      chk8("busy", 8'h00, {7'h00, busy});
      repeat (20) @(negedge mclk);
   endtask

   task automatic t_write(input logic [7:0] ptr, input int len);
      wbuf = '{8'hA5, 8'h3C, 8'hFF, 8'h00};
      widx = 0;
      wr_byte = wbuf[0];
      xfer(1'b0, 1'b1, ptr, 8'(len));
      chk8("nack_err", 8'h00, {7'h00, nack_err});
      chk8("writes", 8'(len), 8'(wq.size()));
      foreach (wq[i]) begin
         chk8("wr_addr", ptr + 8'(i), wq[i][15:8]);
         chk8("wr_data", wbuf[i], wq[i][7:0]);
      end
      $display("test write of %0d bytes done", len);
   endtask

   task automatic t_read(input logic up, input logic [7:0] ptr,
      input logic [7:0] base, input int len);
      xfer(1'b1, up, ptr, 8'(len));
      chk8("reads", 8'(len), 8'(rq.size()));
      foreach (rq[i]) chk8("rd_byte", (base + 8'(i)) ^ 8'h5A, rq[i]);
      chk8("writes", 8'h00, 8'(wq.size()));
      chk8("sda_dev_oe", 8'h00, {7'h00, b1.sda_dev_oe});
      $display("test read of %0d bytes done", len);
   endtask

   // ****************************************
   // hand-driven bus, 8 clocks per half bit
   // ****************************************
   task automatic bb_wait;
      repeat (8) @(negedge mclk);
   endtask

   task automatic bb_bit(input logic b, output logic s);
      b2.sda_host_oe = ~b;
      bb_wait;
      b2.scl_o = 1'b1;
      bb_wait;
      s = b2.sda;
      b2.scl_o = 1'b0;
   endtask

   task automatic bb_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bb_bit(v[i], s);
      bb_bit(1'b1, ack);
   endtask

   // also serves as repeated start when scl is low
   task automatic bb_start;
      b2.sda_host_oe = 1'b0;
      bb_wait;
      b2.scl_o = 1'b1;
      bb_wait;
      b2.sda_host_oe = 1'b1;
      bb_wait;
      b2.scl_o = 1'b0;
   endtask

   task automatic bb_stop;
      b2.sda_host_oe = 1'b1;
      bb_wait;
      b2.scl_o = 1'b1;
      bb_wait;
      b2.sda_host_oe = 1'b0;
      bb_wait;
   endtask

   task automatic t_bad_addr;
      logic a;
      wq2.delete();
      bb_start;
      bb_byte(8'hAA, a);
      chk8("ack_foreign", 8'h01, {7'h00, a});
      bb_byte(8'h00, a);
      chk8("ack_ignored", 8'h01, {7'h00, a});
      bb_start;
      bb_byte({rtp_pkg::TARGET_ADDR, 1'b0}, a);
      chk8("ack_addr", 8'h00, {7'h00, a});
      bb_byte(8'h30, a);
      bb_byte(8'h66, a);
      chk8("ack_data", 8'h00, {7'h00, a});
      bb_stop;
      chk8("wr2_count", 8'h01, 8'(wq2.size()));
      chk8("wr2_addr", 8'h30, wq2[0][15:8]);
      chk8("wr2_data", 8'h66, wq2[0][7:0]);
      $display("test foreign address done");
   endtask

   // target left driving bit 7 of 0x31 ^ 0x5A (low) with scl parked low
   task automatic t_timeout;
      logic a;
      tseen = 1'b0;
      bb_start;
      bb_byte({rtp_pkg::TARGET_ADDR, 1'b1}, a);
      osc_run = 1'b0;
      chk8("ack_read", 8'h00, {7'h00, a});
      repeat (80) @(negedge mclk);
      chk8("held_stopped", 8'h01, {7'h00, b2.sda_dev_oe});
      osc_run = 1'b1;
      repeat (4 * (rtp_pkg::SCL_LOW_SAFE_TICKS - 1)) @(negedge mclk);
      chk8("held_safe", 8'h01, {7'h00, b2.sda_dev_oe});
      repeat (4 * (rtp_pkg::SCL_LOW_RESET_TICKS - rtp_pkg::SCL_LOW_SAFE_TICKS)
         + 16) @(negedge mclk);
      chk8("released", 8'h00, {7'h00, b2.sda_dev_oe});
      chk8("timeout_evt", 8'h01, {7'h00, tseen});
      bb_start;
      bb_byte({rtp_pkg::TARGET_ADDR, 1'b0}, a);
      chk8("ack_after", 8'h00, {7'h00, a});
      bb_stop;
      $display("test scl timeout done");
   endtask

   initial begin
      sys_rst = 1'b1;
      osc_run = 1'b1;
      osc_tick = 1'b0;
      req = 1'b0;
      req_rd = 1'b0;
      req_use_ptr = 1'b0;
      req_ptr = 8'h00;
      req_len = 8'h01;
      wr_byte = 8'h00;
      b2.scl_o = 1'b1;
      b2.scl_oe = 1'b1;
      b2.sda_host_o = 1'b0;
      b2.sda_host_oe = 1'b0;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      t_write(8'h10, 3);
      t_write(8'h40, 1);
      t_read(1'b1, 8'h20, 8'h20, 3);
      t_read(1'b0, 8'h00, 8'h23, 1);
      t_bad_addr;
      t_timeout;
      end_of_test;
   end

   // all tests need about 4000 clocks
   initial begin
      repeat (40000) @(posedge mclk);
      bad_count++;
      end_of_test;
   end
endmodule
